/* core/ucc_pkg.sv */
// Purpose: constants for the serial port control block
// Assumes: 32-bit APB, one word per register
// Notes: offsets and baud divisor are chosen values
package ucc_pkg;
  localparam logic [11:0] FRAME_CTRL_OFFS = 12'h000;
  localparam logic [11:0] IRQ_CTRL_OFFS = 12'h004;
  localparam logic [11:0] NINTH_CTRL_OFFS = 12'h008;
  localparam logic [11:0] STATUS_OFFS = 12'h00C;
  localparam logic [11:0] DATA_OFFS = 12'h010;
  // frame_control fields
  localparam int PORT_EN_BIT = 6;
  localparam int MODE9_BIT = 4;
  localparam int WAKE_SEL_BIT = 3;
  localparam int IDLE_SEL_BIT = 2;
  localparam int PAR_ON_BIT = 1;
  localparam int PAR_ODD_BIT = 0;
  // irq_txrx_control fields
  localparam int TXE_IE_BIT = 7;
  localparam int TXD_IE_BIT = 6;
  localparam int RXF_IE_BIT = 5;
  localparam int RXI_IE_BIT = 4;
  localparam int TX_EN_BIT = 3;
  localparam int RX_EN_BIT = 2;
  localparam int STBY_BIT = 1;
  localparam int BRK_BIT = 0;
  // ninth_bit_error_irq_control fields
  localparam int RX9_BIT = 7;
  localparam int TX9_BIT = 6;
  localparam int ERR_IE_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FRAME_MASK = 8'h5F;
  // bit time in pclk cycles
  localparam logic [7:0] BIT_CYCLES = 8'h10;
  localparam logic [3:0] HALF_BIT = 4'h8;
  localparam logic [3:0] CHAR_BITS_10 = 4'hA;
  localparam logic [3:0] CHAR_BITS_11 = 4'hB;
endpackage : ucc_pkg

/* core/ucc_core.sv */
// Purpose: control, interrupt and format logic of a serial port with a simple shifter
// Assumes: APB slave; single clock; serial input is asynchronous
// Notes: error flags come in as levels from outside receiver checking
`timescale 1ns/100ps
`default_nettype none
module ucc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] rx_err_flags,
  input wire logic rx_pin,
  output logic tx_pin_out,
  output logic tx_pin_oe_n,
  output logic tx_irq,
  output logic rx_irq,
  output logic err_irq
);
  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_BRK} ucc_tx_type;

  logic [7:0] frame_q, irqc_q;
  logic [5:0] errc_q;
  logic rx9_q, tx9_q;
  logic [7:0] txbuf_q, rxbuf_q;
  logic tx_buf_empty, tx_done;
  logic rx_buf_full, rx_idle_flag;
  ucc_tx_type tx_st_q;
  logic [10:0] tsr_q;
  logic [3:0] tbits_q;
  logic [7:0] tcnt_q;
  logic tx_en_prev_q, requeue_q, brk_tail_q, tx_out_q;
  logic rx_s1_q, rx_s2_q;
  logic [3:0] ones_q;
  logic [7:0] rcnt_q;
  logic rx_busy_q, rx_armed_q;
  logic [3:0] rbits_q;
  logic [10:0] rsr_q;

  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire hit_f = paddr == ucc_pkg::FRAME_CTRL_OFFS;
  wire hit_i = paddr == ucc_pkg::IRQ_CTRL_OFFS;
  wire hit_n = paddr == ucc_pkg::NINTH_CTRL_OFFS;
  wire hit_s = paddr == ucc_pkg::STATUS_OFFS;
  wire hit_d = paddr == ucc_pkg::DATA_OFFS;
  wire mapped = hit_f | hit_i | hit_n | hit_s | hit_d;
  wire port_enable = frame_q[ucc_pkg::PORT_EN_BIT];
  wire mode9 = frame_q[ucc_pkg::MODE9_BIT];
  wire wake_addr = frame_q[ucc_pkg::WAKE_SEL_BIT];
  wire idle_count_start_sel = frame_q[ucc_pkg::IDLE_SEL_BIT];
  wire parity_on = frame_q[ucc_pkg::PAR_ON_BIT];
  wire parity_odd_sel = frame_q[ucc_pkg::PAR_ODD_BIT];
  wire tx_enable = irqc_q[ucc_pkg::TX_EN_BIT];
  wire rx_enable = irqc_q[ucc_pkg::RX_EN_BIT];
  wire rx_standby = irqc_q[ucc_pkg::STBY_BIT];
  wire send_brk_ctl = irqc_q[ucc_pkg::BRK_BIT];
  wire [3:0] char_bits = mode9 ? ucc_pkg::CHAR_BITS_11 : ucc_pkg::CHAR_BITS_10;
  wire bit_tick = tcnt_q == ucc_pkg::BIT_CYCLES - 8'h01;
  wire tx_last = bit_tick & (tbits_q == char_bits - 4'h1);

  // parity over the data bits that precede it
  wire [7:0] pdata = mode9 ? txbuf_q : {1'b0, txbuf_q[6:0]};
  wire tx_par = ^pdata ^ parity_odd_sel;
  wire tx_msb = parity_on ? tx_par : (mode9 ? tx9_q : txbuf_q[7]);
  wire [10:0] tx_frame = mode9 ? {1'b1, tx_msb, txbuf_q, 1'b0}
                               : {2'b11, tx_msb, txbuf_q[6:0], 1'b0};

  wire tx_load = tx_st_q == TX_IDLE & tx_enable & ~tx_buf_empty & ~send_brk_ctl;

  // receiver decode; start bit sits at bit 1, data from bit 2 when the stop is sampled
  wire rx_done;
  wire rx_bit = rx_s2_q;
  wire [3:0] rbit_last = char_bits - 4'h1;
  wire rx_sample = rcnt_q == {4'h0, ucc_pkg::HALF_BIT};
  wire bit_tick_rx = rcnt_q == ucc_pkg::BIT_CYCLES - 8'h01;
  wire rx_stop = rx_busy_q & rx_sample & rbits_q == rbit_last;
  assign rx_done = rx_stop & rx_bit & rx_enable & ~rx_standby;
  wire [8:0] rpar_in = mode9 ? rsr_q[10:2] : {1'b0, rsr_q[9:2]};
  wire rx_par_bad = parity_on & (^rpar_in ^ parity_odd_sel);
  wire rx_msb = mode9 ? rsr_q[10] : rsr_q[9];
  wire idle_full = ones_q == char_bits;
  wire wake_hit = wake_addr ? (rx_stop & rx_msb) : idle_full;
  logic rx_par_err_q;

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= ucc_pkg::CTRL_RESET;
      irqc_q <= ucc_pkg::CTRL_RESET;
      errc_q <= 6'h00;
    end else if (clk_en) begin
      if (wr & hit_f) begin
        frame_q <= pwdata[7:0] & ucc_pkg::FRAME_MASK;
      end
      if (wr & hit_i) begin
        irqc_q <= pwdata[7:0];
      end else if (rx_standby & wake_hit) begin
        irqc_q[ucc_pkg::STBY_BIT] <= 1'b0;
      end
      if (wr & hit_n) begin
        errc_q <= pwdata[5:0];
      end
    end
  end

  // ninth bits and data buffers survive reset
  always_ff @(posedge pclk) begin
    if (clk_en) begin
      if (wr & hit_n) begin
        tx9_q <= pwdata[ucc_pkg::TX9_BIT];
      end
      if (wr & hit_d) begin
        txbuf_q <= pwdata[7:0];
      end
      if (rx_done) begin
        rxbuf_q <= rsr_q[9:2];
        rx9_q <= rx_msb;
      end
    end
  end

  // transmit flags: empty sets on load, done while nothing sent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_empty <= 1'b1;
      tx_done <= 1'b1;
    end else if (clk_en) begin
      if (!port_enable) begin
        tx_buf_empty <= 1'b1;
        tx_done <= 1'b1;
      end else begin
        if (tx_load) begin
          tx_buf_empty <= 1'b1;
        end else if (wr & hit_d) begin
          tx_buf_empty <= 1'b0;
        end
        tx_done <= tx_st_q == TX_IDLE & ~tx_load & ~requeue_q & ~brk_tail_q
                   & tx_buf_empty & ~(tx_enable & ~tx_en_prev_q) & ~send_brk_ctl;
      end
    end
  end

  // transmitter sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tsr_q <= 11'h7FF;
      tbits_q <= 4'h0;
      tcnt_q <= 8'h00;
      tx_en_prev_q <= 1'b0;
      requeue_q <= 1'b0;
      brk_tail_q <= 1'b0;
      tx_out_q <= 1'b1;
    end else if (clk_en) begin
      tx_en_prev_q <= tx_enable;
      if (tx_st_q != TX_IDLE & tx_enable & ~tx_en_prev_q) begin
        requeue_q <= 1'b1;
      end
      tcnt_q <= (tx_st_q == TX_IDLE | bit_tick) ? 8'h00 : tcnt_q + 8'h01;
      case (tx_st_q)
        TX_IDLE: begin
          tbits_q <= 4'h0;
          tx_out_q <= 1'b1;
          if (tx_enable & send_brk_ctl) begin
            tx_st_q <= TX_BRK;
            tx_out_q <= 1'b0;
          end else if (tx_enable & (~tx_en_prev_q | requeue_q | brk_tail_q)) begin
            tx_st_q <= TX_PRE;
            requeue_q <= 1'b0;
            brk_tail_q <= 1'b0;
          end else if (tx_load) begin
            tsr_q <= tx_frame;
            tx_out_q <= 1'b0;
            tx_st_q <= TX_DATA;
          end
        end
        TX_PRE: begin
          if (tx_last | (brk_tail_q & bit_tick)) begin
            tx_st_q <= TX_IDLE;
            brk_tail_q <= 1'b0;
          end
          if (bit_tick) begin
            tbits_q <= tbits_q + 4'h1;
          end
        end
        TX_DATA: begin
          if (bit_tick) begin
            tsr_q <= {1'b1, tsr_q[10:1]};
            tx_out_q <= tsr_q[1];
            tbits_q <= tbits_q + 4'h1;
          end
          if (tx_last) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: begin
          tx_out_q <= 1'b0;
          if (bit_tick) begin
            tbits_q <= tbits_q + 4'h1;
          end
          if (tx_last) begin
            tbits_q <= 4'h0;
            if (!send_brk_ctl) begin
              tx_st_q <= TX_PRE;
              tx_out_q <= 1'b1;
              brk_tail_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_busy_q <= 1'b0;
      rcnt_q <= 8'h00;
      rbits_q <= 4'h0;
      rsr_q <= 11'h000;
      ones_q <= 4'h0;
      rx_armed_q <= 1'b0;
      rx_buf_full <= 1'b0;
      rx_idle_flag <= 1'b0;
      rx_par_err_q <= 1'b0;
    end else if (clk_en) begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      if (rd & hit_d) begin
        rx_buf_full <= 1'b0;
        rx_idle_flag <= 1'b0;
        rx_par_err_q <= 1'b0;
      end
      if (!rx_enable) begin
        rx_busy_q <= 1'b0;
        ones_q <= 4'h0;
      end else if (!rx_busy_q) begin
        rbits_q <= 4'h0;
        if (!rx_bit) begin
          rx_busy_q <= 1'b1;
          rcnt_q <= 8'h00;
          ones_q <= 4'h0;
        end else begin
          // idle ones are counted per bit time, not per clock
          rcnt_q <= bit_tick_rx ? 8'h00 : rcnt_q + 8'h01;
          if (bit_tick_rx & !idle_full) begin
            ones_q <= ones_q + 4'h1;
          end
        end
      end else begin
        rcnt_q <= bit_tick_rx ? 8'h00 : rcnt_q + 8'h01;
        if (rx_sample) begin
          rsr_q <= mode9 ? {rx_bit, rsr_q[10:1]} : {1'b0, rx_bit, rsr_q[9:1]};
          rbits_q <= rbits_q + 4'h1;
          // ones after start count toward idle when idle_count_start_sel is clear
          if (!idle_count_start_sel & rbits_q != 4'h0) begin
            ones_q <= rx_bit ? ones_q + 4'h1 : 4'h0;
          end
        end
        if (rx_stop) begin
          rx_busy_q <= 1'b0;
          if (idle_count_start_sel) begin
            ones_q <= 4'h0;
          end
        end
      end
      if (rx_done) begin
        rx_buf_full <= 1'b1;
        rx_armed_q <= 1'b1;
        rx_par_err_q <= rx_par_bad;
      end
      if (idle_full & rx_armed_q & ~rx_standby) begin
        rx_idle_flag <= 1'b1;
        rx_armed_q <= 1'b0;
      end
    end
  end
  // interrupt requests
  wire [3:0] err_src = rx_err_flags | {3'b000, rx_par_err_q};
  wire [3:0] err_en = errc_q[3:0];
  assign tx_irq = port_enable & ((tx_buf_empty & irqc_q[ucc_pkg::TXE_IE_BIT])
                  | (tx_done & irqc_q[ucc_pkg::TXD_IE_BIT]));
  assign rx_irq = ~rx_standby & ((rx_buf_full & irqc_q[ucc_pkg::RXF_IE_BIT])
                  | (rx_idle_flag & irqc_q[ucc_pkg::RXI_IE_BIT]));
  assign err_irq = |(err_src & err_en);

  // read mux
  wire [7:0] status = {tx_buf_empty, tx_done, rx_buf_full, rx_idle_flag, err_src};
  wire [7:0] rd_byte = hit_f ? frame_q : hit_i ? irqc_q
                     : hit_n ? {rx9_q, tx9_q, errc_q} : hit_s ? status
                     : hit_d ? rxbuf_q : 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en & psel & ~penable) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign tx_pin_out = 1'b0;
  assign tx_pin_oe_n = tx_out_q | ~port_enable;

  tx_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!irqc_q[ucc_pkg::TXE_IE_BIT] & !irqc_q[ucc_pkg::TXD_IE_BIT]) |-> !tx_irq)
    else $error("tx irq without enable");
  txoff_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en & !port_enable) |=> (tx_buf_empty & tx_done))
    else $error("port disable did not set tx flags");
  standby_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_standby |-> !rx_irq)
    else $error("rx irq in standby");
  err_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_irq |-> |(err_src & errc_q[3:0]))
    else $error("error irq ungated");
  brk_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_st_q == TX_BRK & $past(tx_st_q) == TX_BRK) |-> !tx_out_q)
    else $error("break not low");
  pre_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_st_q == TX_PRE) |-> tx_out_q)
    else $error("preamble not high");
  idle_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en & tx_st_q == TX_IDLE & !tx_enable) |=> tx_out_q)
    else $error("tx not idle high");
  rx_idle_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en & !rx_enable & rx_buf_full & !(rd & hit_d)) |=> rx_buf_full)
    else $error("rx flag lost on disable");
endmodule : ucc_core
`default_nettype wire

/* bench/ucc_remote.sv */
// Purpose: remote serial station facing the port
// Assumes: 16 pclk per bit, lsb first, line idles high
// Notes: sends on the receive line, samples the open-drain transmit line
`timescale 1ns/100ps
`default_nettype none
module ucc_remote (
  input wire logic pclk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  // start bit in bit 0, stop bit last
  task automatic send(input logic [10:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      rx_line <= b[i];
      repeat (16) @(posedge pclk);
    end
  endtask
  // waits for a start bit, then samples each bit at its middle
  task automatic grab(input int n, output logic [10:0] b, output int k);
    b = 11'h000;
    k = 0;
    while (tx_line !== 1'b0 && k < 4000) begin
      @(posedge pclk);
      k++;
    end
    repeat (8) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      b[i] = tx_line;
      repeat (16) @(posedge pclk);
    end
  endtask
endmodule // ucc_remote
`default_nettype wire

/* bench/test_uart_control_interrupt_config.sv */
// Purpose: self-checking bench for the serial port control block
// Assumes: zero-wait APB, 16 pclk per serial bit
// Notes: random register traffic plus framing, standby and interrupt corners
`timescale 1ns/100ps
`default_nettype none
module test_uart_control_interrupt_config;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] rx_err_flags = 4'h0;
  logic [31:0] prdata, r, v, fc;
  logic pready, pslverr, rx_pin, tx_pin_out, tx_pin_oe_n, tx_irq, rx_irq, err_irq, txl, se;
  logic [10:0] got;
  logic [7:0] d;
  logic [2:0] cfg;
  logic [2:0] tab [5] = '{3'b000, 3'b010, 3'b011, 3'b100, 3'b111};
  int errors = 0;
  int total_checks = 0;
  int seed = 49542;
  int k;
  always #10 pclk = ~pclk;
  // pull-up on the open-drain line
  assign txl = tx_pin_oe_n ? 1'b1 : tx_pin_out;
  ucc_core u_ucc_core (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_err_flags(rx_err_flags), .rx_pin(rx_pin),
    .tx_pin_out(tx_pin_out), .tx_pin_oe_n(tx_pin_oe_n), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .err_irq(err_irq));
  ucc_remote u_ucc_remote (.pclk(pclk), .tx_line(txl), .rx_line(rx_pin));
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  function automatic logic [31:0] bt(input int p);
    bt = 32'h1 << p;
  endfunction
  // expected character, start bit in bit 0
  function automatic logic [10:0] frm(input logic m9, input logic pon, input logic odd,
    input logic t8, input logic [7:0] x);
    if (m9) frm = {1'b1, pon ? ^x ^ odd : t8, x, 1'b0};
    else frm = {2'b01, pon ? ^x[6:0] ^ odd : x[7], x[6:0], 1'b0};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] x);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      errors++;
      report_and_stop;
    end
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask
  task automatic cyc;
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ucc_pkg::FRAME_CTRL_OFFS, 32'hFF, 32'h0);
    rdchk(ucc_pkg::IRQ_CTRL_OFFS, 32'hFF, 32'h0);
    rdchk(ucc_pkg::NINTH_CTRL_OFFS, 32'h3F, 32'h0);
    rdchk(ucc_pkg::STATUS_OFFS, 32'hC0, 32'hC0);
    apb(1'b0, 12'h0F0, 32'h0);
    chk({31'h0, se}, 32'h1);
    chk(r, 32'h0);
    // only interrupt enables are written while the port is off
    apb(1'b1, ucc_pkg::IRQ_CTRL_OFFS, bt(ucc_pkg::TXE_IE_BIT));
    cyc;
    chk1(tx_irq, 1'b0);
    apb(1'b1, ucc_pkg::FRAME_CTRL_OFFS, bt(ucc_pkg::PORT_EN_BIT));
    for (int i = 0; i < 4; i++) begin
      v = (32'(i[1]) << ucc_pkg::TXE_IE_BIT) | (32'(i[0]) << ucc_pkg::TXD_IE_BIT);
      apb(1'b1, ucc_pkg::IRQ_CTRL_OFFS, v);
      cyc;
      chk1(tx_irq, i != 0);
    end
    rx_err_flags <= 4'hF;
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      // format fields change only while the line is idle
      fc = (v & ucc_pkg::FRAME_MASK) | bt(ucc_pkg::PORT_EN_BIT);
      apb(1'b1, ucc_pkg::FRAME_CTRL_OFFS, fc);
      rdchk(ucc_pkg::FRAME_CTRL_OFFS, 32'hFF, fc);
      // each error enable alone, then random, then none; dma enables kept low
      v = (i < 4) ? ((v & 32'h40) | bt(i)) : (v & 32'h4F);
      if (i == 7) v = v & 32'h40;
      apb(1'b1, ucc_pkg::NINTH_CTRL_OFFS, v);
      rdchk(ucc_pkg::NINTH_CTRL_OFFS, 32'h7F, v);
      cyc;
      chk1(err_irq, |v[3:0]);
    end
    rx_err_flags <= 4'h0;
    for (int i = 0; i < 5; i++) begin
      cfg = tab[i];
      v = $random(seed);
      d = v[7:0];
      fc = bt(ucc_pkg::PORT_EN_BIT) | (32'(cfg[2]) << ucc_pkg::MODE9_BIT);
      fc = fc | (32'(cfg[1]) << ucc_pkg::PAR_ON_BIT) | (32'(cfg[0]) << ucc_pkg::PAR_ODD_BIT);
      apb(1'b1, ucc_pkg::FRAME_CTRL_OFFS, fc);
      apb(1'b1, ucc_pkg::NINTH_CTRL_OFFS, 32'(v[8]) << ucc_pkg::TX9_BIT);
      if (i == 0) apb(1'b1, ucc_pkg::IRQ_CTRL_OFFS, bt(ucc_pkg::TX_EN_BIT));
      apb(1'b1, ucc_pkg::DATA_OFFS, {24'h0, d});
      u_ucc_remote.grab(cfg[2] ? 11 : 10, got, k);
      chk({21'h0, got}, {21'h0, frm(cfg[2], cfg[1], cfg[0], v[8], d)});
      if (i == 0) chk1(k > 140, 1'b1);
      if (k >= 4000) begin
        errors++;
        report_and_stop;
      end
    end
    apb(1'b1, ucc_pkg::FRAME_CTRL_OFFS, bt(ucc_pkg::PORT_EN_BIT) | bt(ucc_pkg::WAKE_SEL_BIT));
    fc = bt(ucc_pkg::TX_EN_BIT) | bt(ucc_pkg::RXF_IE_BIT);
    apb(1'b1, ucc_pkg::IRQ_CTRL_OFFS, fc | bt(ucc_pkg::RX_EN_BIT));
    d = 8'($random(seed));
    u_ucc_remote.send(frm(1'b0, 1'b0, 1'b0, 1'b0, d), 10);
    k = 0;
    do begin
      apb(1'b0, ucc_pkg::STATUS_OFFS, 32'h0);
      k++;
    end while (r[5] !== 1'b1 && k < 100);
    chk(r & 32'h20, 32'h20);
    if (r[5] !== 1'b1) report_and_stop;
    cyc;
    chk1(rx_irq, 1'b1);
    apb(1'b1, ucc_pkg::IRQ_CTRL_OFFS, fc | bt(ucc_pkg::RX_EN_BIT) | bt(ucc_pkg::STBY_BIT));
    cyc;
    chk1(rx_irq, 1'b0);
    apb(1'b1, ucc_pkg::IRQ_CTRL_OFFS, fc);
    rdchk(ucc_pkg::STATUS_OFFS, 32'h20, 32'h20);
    cyc;
    chk1(rx_irq, 1'b1);
    rdchk(ucc_pkg::NINTH_CTRL_OFFS, 32'h80, {24'h0, d[7], 7'h0});
    rdchk(ucc_pkg::DATA_OFFS, 32'hFF, {24'h0, d});
    cyc;
    chk1(rx_irq, 1'b0);
    apb(1'b1, ucc_pkg::IRQ_CTRL_OFFS, bt(ucc_pkg::TX_EN_BIT) | bt(ucc_pkg::BRK_BIT));
    u_ucc_remote.grab(10, got, k);
    chk({21'h0, got}, 32'h0);
    if (k >= 4000) begin
      errors++;
      report_and_stop;
    end
    apb(1'b1, ucc_pkg::IRQ_CTRL_OFFS, bt(ucc_pkg::TX_EN_BIT));
    repeat (200) @(posedge pclk);
    chk1(txl, 1'b1);
    rdchk(ucc_pkg::STATUS_OFFS, 32'hC0, 32'hC0);
    report_and_stop;
  end
endmodule // test_uart_control_interrupt_config
`default_nettype wire
